/* File: design/rsc_regs.sv */
// register slice: detect thresholds, lane A swing and reserved configuration bytes
`timescale 1ns/1ps

module rsc_regs (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    input  wire logic       load_en,
    input  wire logic [7:0] load_addr,
    input  wire logic [7:0] load_data,
    input  wire logic       detect_override,
    input  wire logic       detect_level_pin,
    input  wire logic [7:0] input_amplitude_mv,
    output logic            signal_detect,
    output logic      [1:0] assert_level_code,
    output logic      [1:0] deassert_level_code,
    output logic      [7:0] assert_threshold_mv,
    output logic      [7:0] deassert_threshold_mv,
    output logic      [2:0] lane_a_swing_code
);
    logic [7:0] regs_r   [rsc_pkg::NUM_REGS];
    logic [7:0] regs_nxt [rsc_pkg::NUM_REGS];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rd_valid_r;
    logic       rd_valid_nxt;
    logic       pin_meta_r;
    logic       pin_sync_r;
    logic [1:0] acode_r;
    logic [1:0] acode_nxt;
    logic [1:0] dcode_r;
    logic [1:0] dcode_nxt;
    logic [7:0] athr_r;
    logic [7:0] athr_nxt;
    logic [7:0] dthr_r;
    logic [7:0] dthr_nxt;
    logic [2:0] swing_r;
    logic [2:0] swing_nxt;
    logic       sd_r;
    logic       sd_nxt;

    localparam logic [7:0] SWING_REG_RST = rsc_pkg::REG_RST[rsc_pkg::IDX_SWING_A];

    // the threshold pin is asynchronous to clk
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= detect_level_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    always_comb begin
        for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
            // loader wins over a bus write to the same cycle
            if (load_en && load_addr == rsc_pkg::REG_ADDR[i]) begin
                regs_nxt[i] = (regs_r[i] & ~rsc_pkg::REG_WMASK[i])
                            | (load_data & rsc_pkg::REG_WMASK[i]);
            end else if (reg_wr_en && reg_addr == rsc_pkg::REG_ADDR[i]) begin
                regs_nxt[i] = (regs_r[i] & ~rsc_pkg::REG_WMASK[i])
                            | (reg_wdata & rsc_pkg::REG_WMASK[i]);
            end
        end
        rdata_nxt    = rdata_r;
        rd_valid_nxt = reg_rd_en;
        if (reg_rd_en) begin
            rdata_nxt = rsc_pkg::RD_UNMAPPED;
            for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
                if (reg_addr == rsc_pkg::REG_ADDR[i]) begin
                    rdata_nxt = regs_r[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
                regs_r[i] <= rsc_pkg::REG_RST[i];
            end
            rdata_r    <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            rdata_r    <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // threshold selection; the registered codes also drive assert_level_code and deassert_level_code
    always_comb begin
        if (detect_override) begin
            acode_nxt = regs_r[rsc_pkg::IDX_CHB_THR][rsc_pkg::ASSERT_MSB:rsc_pkg::ASSERT_LSB];
            dcode_nxt = regs_r[rsc_pkg::IDX_CHB_THR][rsc_pkg::DEASSERT_MSB:rsc_pkg::DEASSERT_LSB];
        end else begin
            acode_nxt = pin_sync_r ? rsc_pkg::PIN_HIGH_CODE : rsc_pkg::PIN_LOW_CODE;
            dcode_nxt = pin_sync_r ? rsc_pkg::PIN_HIGH_CODE : rsc_pkg::PIN_LOW_CODE;
        end
        athr_nxt  = rsc_pkg::assert_mv(acode_r);
        dthr_nxt  = rsc_pkg::deassert_mv(dcode_r);
        swing_nxt = regs_r[rsc_pkg::IDX_SWING_A][rsc_pkg::SWING_MSB:rsc_pkg::SWING_LSB];
        // hysteresis: set at the assert level, released below the lower one
        sd_nxt = sd_r;
        if (!sd_r && input_amplitude_mv >= athr_r) begin
            sd_nxt = 1'b1;
        end else if (sd_r && input_amplitude_mv < dthr_r) begin
            sd_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acode_r <= rsc_pkg::PIN_LOW_CODE;
            dcode_r <= rsc_pkg::PIN_LOW_CODE;
            athr_r  <= 8'hFF;
            dthr_r  <= 8'h00;
            // follow the register's reset byte so the code never steps after release
            swing_r <= SWING_REG_RST[rsc_pkg::SWING_MSB:rsc_pkg::SWING_LSB];
            sd_r    <= 1'b0;
        end else begin
            acode_r <= acode_nxt;
            dcode_r <= dcode_nxt;
            athr_r  <= athr_nxt;
            dthr_r  <= dthr_nxt;
            swing_r <= swing_nxt;
            sd_r    <= sd_nxt;
        end
    end

    assign reg_rdata             = rdata_r;
    assign reg_rd_valid          = rd_valid_r;
    assign assert_level_code     = acode_r;
    assign deassert_level_code   = dcode_r;
    assign assert_threshold_mv   = athr_r;
    assign deassert_threshold_mv = dthr_r;
    assign lane_a_swing_code     = swing_r;
    assign signal_detect         = sd_r;

    // true for every offset that this slice owns
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = 1'b0;
        for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
            if (a == rsc_pkg::REG_ADDR[i]) begin
                addr_mapped = 1'b1;
            end
        end
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_thr_write;
        reg_wr_en && !load_en && reg_addr == rsc_pkg::ADDR_CHB_THR;
    endsequence
    sequence s_thr_read;
        reg_rd_en && !reg_wr_en && !load_en && reg_addr == rsc_pkg::ADDR_CHB_THR;
    endsequence
    sequence s_unmapped_read;
        reg_rd_en && !addr_mapped(reg_addr);
    endsequence

    AST_WRITE_READBACK: assert property (
        s_thr_write ##1 s_thr_read |=> reg_rd_valid && reg_rdata == $past(reg_wdata, 2))
        else $error("threshold register readback differs from last write");
    AST_OVERRIDE_CODES: assert property (
        $past(detect_override) |->
        assert_level_code == $past(regs_r[rsc_pkg::IDX_CHB_THR][3:2])
        && deassert_level_code == $past(regs_r[rsc_pkg::IDX_CHB_THR][1:0]))
        else $error("override codes not taken from threshold register");
    AST_PIN_MODE: assert property (
        !$past(detect_override) |->
        assert_level_code == ($past(pin_sync_r) ? rsc_pkg::PIN_HIGH_CODE : rsc_pkg::PIN_LOW_CODE))
        else $error("pin mode threshold code wrong");
    AST_DEASSERT_MV: assert property (
        !$past(srst) |->
        deassert_threshold_mv == rsc_pkg::deassert_mv($past(deassert_level_code)))
        else $error("release threshold does not follow code");
    AST_SD_RISE: assert property (
        $rose(signal_detect) |-> $past(input_amplitude_mv) >= $past(assert_threshold_mv))
        else $error("signal detect rose below assert level");
    AST_SWING_FIXED: assert property (
        regs_r[rsc_pkg::IDX_SWING_A][7:5] == rsc_pkg::SWING_TOP_FIX
        && regs_r[rsc_pkg::IDX_SWING_A][1:0] == rsc_pkg::SWING_LOW_FIX
        && lane_a_swing_code == $past(regs_r[rsc_pkg::IDX_SWING_A][4:2]))
        else $error("swing register fixed bits or code output wrong");
    // release edge: threshold and swing registers and status still show their reset values
    AST_RESET_DEFAULTS: assert property (
        $past(srst) |->
        regs_r[rsc_pkg::IDX_CHB_THR] == rsc_pkg::REG_RST[rsc_pkg::IDX_CHB_THR]
        && regs_r[rsc_pkg::IDX_SWING_A] == rsc_pkg::REG_RST[rsc_pkg::IDX_SWING_A]
        && !reg_rd_valid && !signal_detect)
        else $error("register defaults missing after reset");
    AST_ASSERT_MV: assert property (
        !$past(srst) |->
        assert_threshold_mv == rsc_pkg::assert_mv($past(assert_level_code)))
        else $error("assert threshold does not follow code");
    AST_SD_FALL: assert property (
        $fell(signal_detect) |-> $past(input_amplitude_mv) < $past(deassert_threshold_mv))
        else $error("signal detect fell above release level");
    AST_SD_HOLD: assert property (
        signal_detect && input_amplitude_mv >= deassert_threshold_mv |=> signal_detect)
        else $error("signal detect dropped inside hysteresis band");
    AST_UNMAPPED_READ: assert property (
        s_unmapped_read |=> reg_rd_valid && reg_rdata == rsc_pkg::RD_UNMAPPED)
        else $error("unmapped read did not return the empty value");
    AST_READ_VALID: assert property (
        !$past(srst) |-> reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after strobe");
    AST_CFG26_FIXED: assert property (
        regs_r[rsc_pkg::IDX_CFG_26][7:5] == rsc_pkg::REG_RST[rsc_pkg::IDX_CFG_26][7:5])
        else $error("read-only bits of the last reserved byte changed");
endmodule

/* File: design/rsc_pkg.sv */
// constants for the signal-detect threshold and output-swing register slice
package rsc_pkg;
    localparam int NUM_REGS = 10;

    localparam logic [7:0] ADDR_CHB_THR  = 8'h19;
    localparam logic [7:0] ADDR_SWING_A  = 8'h25;
    localparam logic [7:0] ADDR_CFG_26   = 8'h26;

    localparam int IDX_CHB_THR  = 0;
    localparam int IDX_SWING_A  = 8;
    localparam int IDX_CFG_26   = 9;

    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        8'h19, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26};
    localparam logic [7:0] REG_RST  [NUM_REGS] = '{
        8'h00, 8'h00, 8'h2F, 8'hAD, 8'h02, 8'h00, 8'h00, 8'h2F, 8'hAD, 8'h02};
    // bits outside the mask keep their reset pattern
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1C, 8'h1F};

    localparam int ASSERT_MSB   = 3;
    localparam int ASSERT_LSB   = 2;
    localparam int DEASSERT_MSB = 1;
    localparam int DEASSERT_LSB = 0;
    localparam int SWING_MSB    = 4;
    localparam int SWING_LSB    = 2;

    localparam logic [2:0] SWING_RST      = 3'h5;
    localparam logic [2:0] SWING_TOP_FIX  = 3'h5;
    localparam logic [1:0] SWING_LOW_FIX  = 2'h1;
    localparam logic [1:0] PIN_LOW_CODE   = 2'h0;
    localparam logic [1:0] PIN_HIGH_CODE  = 2'h2;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // assert levels in mV for codes 0..3
    function automatic logic [7:0] assert_mv(input logic [1:0] code);
        case (code)
            2'h0:    assert_mv = 8'h32;
            2'h1:    assert_mv = 8'h28;
            2'h2:    assert_mv = 8'h4B;
            default: assert_mv = 8'h3A;
        endcase
    endfunction

    // release levels in mV for codes 0..3
    function automatic logic [7:0] deassert_mv(input logic [1:0] code);
        case (code)
            2'h0:    deassert_mv = 8'h25;
            2'h1:    deassert_mv = 8'h16;
            2'h2:    deassert_mv = 8'h37;
            default: deassert_mv = 8'h2D;
        endcase
    endfunction
endpackage

/* File: test/rsc_loader_model.sv */
// serial-memory loader model that programs the recommended lane A swing
`timescale 1ns/1ps
module rsc_loader_model (
    input  wire logic       clk,
    input  wire logic       start,
    output logic            load_en,
    output logic      [7:0] load_addr,
    output logic      [7:0] load_data,
    output logic            done
);
    initial begin
        load_en   = 1'b0;
        load_addr = 8'hDA;
        load_data = 8'h47;
        done      = 1'b0;
        forever begin
            @(posedge clk iff start);
            #1;
            load_en   = 1'b1;
            load_addr = 8'h25;
            load_data = 8'hB8;
            @(posedge clk);
            #1;
            load_en   = 1'b0;
            // released bus shows the inverse of the last value, not a stale copy
            load_addr = 8'hDA;
            load_data = 8'h47;
            done      = 1'b1;
        end
    end
endmodule

/* File: test/test_redriver_sd_swing_config_regs.sv */
// self-checking bench for the threshold and swing register slice
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module test_redriver_sd_swing_config_regs;
    logic       clk, srst, wr_en, rd_en, ld_start, ovr, pin, ld_done, rd_valid, ld_en, sd;
    logic [7:0] addr, wdata, amp, rdata, ld_addr, ld_data, athr, dthr;
    logic [1:0] acode, dcode;
    logic [2:0] swing;
    int         fail_count, checks_done, cycles;
    // address, write data, reset value, readback after the write
    logic [7:0] rows [11][4] = '{'{8'h1C, 8'hFF, 8'h00, 8'hFF}, '{8'h1D, 8'h55, 8'h2F, 8'h55},
        '{8'h1E, 8'h12, 8'hAD, 8'h12}, '{8'h1F, 8'h34, 8'h02, 8'h34},
        '{8'h20, 8'h56, 8'h00, 8'h56}, '{8'h23, 8'h78, 8'h00, 8'h78},
        '{8'h24, 8'h9A, 8'h2F, 8'h9A}, '{8'h25, 8'hFF, 8'hAD, 8'hBD},
        '{8'h26, 8'hFF, 8'h02, 8'h1F}, '{8'h30, 8'h77, 8'h00, 8'h00},
        '{8'h19, 8'h0C, 8'h00, 8'h0C}};

    rsc_regs dut_u (.clk(clk), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
        .load_en(ld_en), .load_addr(ld_addr), .load_data(ld_data), .detect_override(ovr),
        .detect_level_pin(pin), .input_amplitude_mv(amp), .signal_detect(sd),
        .assert_level_code(acode), .deassert_level_code(dcode), .assert_threshold_mv(athr),
        .deassert_threshold_mv(dthr), .lane_a_swing_code(swing));
    rsc_loader_model loader_u (.clk(clk), .start(ld_start), .load_en(ld_en),
        .load_addr(ld_addr), .load_data(ld_data), .done(ld_done));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1 wdata = d;
        addr = a;
        wr_en = 1'b1;
        @(posedge clk) #1 wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1 addr = a;
        rd_en = 1'b1;
        @(posedge clk) #1 rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rdata, exp)
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        {srst, wr_en, rd_en, ld_start, ovr, pin, addr, wdata, amp} = {1'b1, 5'h00, 24'h000000};
        wait_cycles(10);
        srst = 1'b0;
        `CHK(swing, 3'h3)
        `CHK({acode, dcode}, 4'h0)
        foreach (rows[i]) rd(rows[i][0], rows[i][2]);
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rows[i][3]);
        end
        `CHK(swing, 3'h7)
        $display("test register table done");
        ovr = 1'b1;
        wait_cycles(4);
        `CHK({acode, dcode}, 4'hC)
        `CHK({athr, dthr}, 16'h3A25)
        `CHK(swing, 3'h7)
        amp = 8'h3A;
        wait_cycles(3);
        `CHK(sd, 1'b1)
        amp = 8'h25;
        wait_cycles(3);
        `CHK(sd, 1'b1)
        amp = 8'h24;
        wait_cycles(3);
        `CHK(sd, 1'b0)
        $display("test override thresholds done");
        ovr = 1'b0;
        pin = 1'b1;
        wait_cycles(6);
        `CHK({acode, dcode, athr}, 12'hA4B)
        $display("test pin thresholds done");
        ld_start = 1'b1;
        wait_cycles(1);
        ld_start = 1'b0;
        for (int k = 0; k < 20 && ld_done !== 1'b1; k++) wait_cycles(1);
        rd(8'h25, 8'hB9);
        `CHK(swing, 3'h6)
        @(posedge clk) #1 addr = 8'h19;
        wdata = 8'h05;
        wr_en = 1'b1;
        @(posedge clk) #1 wr_en = 1'b0;
        rd_en = 1'b1;
        @(posedge clk) #1 rd_en = 1'b0;
        `CHK(rdata, 8'h05)
        @(posedge clk) #1 wdata = 8'h0A;
        wr_en = 1'b1;
        rd_en = 1'b1;
        @(posedge clk) #1 wr_en = 1'b0;
        rd_en = 1'b0;
        `CHK(rdata, 8'h05)
        rd(8'h19, 8'h0A);
        $display("test back-to-back access done");
        srst = 1'b1;
        wait_cycles(2);
        srst = 1'b0;
        `CHK({athr, dthr}, 16'hFF00)
        `CHK({sd, acode, dcode, swing}, 8'h03)
        rd(8'h19, 8'h00);
        rd(8'h25, 8'hAD);
        $display("test loader and second reset done");
        print_verdict();
    end
endmodule
